//--- bwm_pkg.sv
package bwm_pkg;

  // organisation codes held in the control register
  localparam logic [1:0] BWM_ORG_X8  = 2'h0;
  localparam logic [1:0] BWM_ORG_X9  = 2'h1;
  localparam logic [1:0] BWM_ORG_X18 = 2'h2;
  localparam logic [1:0] BWM_ORG_X36 = 2'h3;

  // lane geometry of the data beat and queue depth
  localparam int BWM_DATA_W   = 36;
  localparam int BWM_NIB_W    = 4;
  localparam int BWM_LANE_W   = 9;
  localparam int BWM_SEL_W    = 4;
  localparam int BWM_FIFO_DEP = 32;

  // register byte offsets on the slave bus
  localparam logic [4:0] BWM_CTRL_OFS    = 5'h00;
  localparam logic [4:0] BWM_STATUS_OFS  = 5'h04;
  localparam logic [4:0] BWM_MADDR_OFS   = 5'h08;
  localparam logic [4:0] BWM_MDATA_L_OFS = 5'h0C;
  localparam logic [4:0] BWM_MDATA_H_OFS = 5'h10;

  // control field positions and reset values
  localparam int         BWM_CTRL_ORG_LSB  = 0;
  localparam int         BWM_CTRL_HOLD_BIT = 2;
  localparam logic [1:0] BWM_ORG_RST       = BWM_ORG_X36;
  localparam logic       BWM_HOLD_RST      = 1'b0;

  // status field positions
  localparam int BWM_ST_EMPTY_BIT = 0;
  localparam int BWM_ST_FULL_BIT  = 1;
  localparam int BWM_ST_OVF_BIT   = 2;
  localparam int BWM_ST_BUSY_BIT  = 3;
  localparam int BWM_ST_LVL_LSB   = 8;
  localparam int BWM_ST_CNT_LSB   = 16;

  // write burst sequencer states
  typedef enum logic [2:0] {
    BWM_ST_IDLE  = 3'h1,
    BWM_ST_BEAT0 = 3'h2,
    BWM_ST_BEAT1 = 3'h4
  } bwm_wr_state_e;

endpackage

//--- bwm_fifo.sv
`timescale 1ns/10ps
module bwm_fifo
  import bwm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = BWM_FIFO_DEP
)
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]      level_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int LVL_W = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [LVL_W-1:0]            level;
  } bwm_fifo_s;

  bwm_fifo_s s_reg;
  bwm_fifo_s s_next;
  logic      push;
  logic      pop;

  // honest flags straight from the level register
  assign in_ready_o  = (s_reg.level != LVL_W'(DEPTH));
  assign out_valid_o = (s_reg.level != '0);
  assign out_data_o  = s_reg.mem[s_reg.rd_ptr];
  assign level_o     = s_reg.level;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointer and level update
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.mem[s_reg.wr_ptr] = in_data_i;
      s_next.wr_ptr = (s_reg.wr_ptr == PTR_W'(DEPTH-1)) ? '0 : s_reg.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      s_next.rd_ptr = (s_reg.rd_ptr == PTR_W'(DEPTH-1)) ? '0 : s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      s_next.level = s_reg.level + 1'b1;
    end
    else if (pop && !push)
    begin
      s_next.level = s_reg.level - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

//--- bwm_write_lane_mask.sv
`timescale 1ns/10ps
// Behaviour
// R1: write starts on load_strobe and read_write_select low
// R2: beat A at next positive, A+1 at negative
// R3: selects sampled separately with every beat
// R4: x8 both selects low store all eight
// R5: x8 select0 only writes bits 3..0
// R6: x8 select1 only writes bits 7..4
// R7: x18 both selects low store eighteen bits
// R8: x18 select0 only writes bits 8..0
// R9: x18 select1 only writes bits 17..9
// R10: x8/x18 both selects high write nothing
// R11: x9 single select governs bits 8..0
// R12: x36 all selects low store all bits
// R13: x36 select0 only writes bits 8..0
// R14: x36 select1 only writes bits 17..9
// R15: x36 select2 only writes bits 26..18
// R16: x36 select3 only writes bits 35..27
// R17: x36 all selects high write nothing
// R18: lanes independent, mask tied to own beat
module bwm_write_lane_mask
  import bwm_pkg::*;
#(
  parameter int ADDR_W = 6
)
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  // memory-side pins, synchronous to clk_i
  input  wire logic                  pos_strobe_i,
  input  wire logic                  neg_strobe_i,
  input  wire logic                  load_strobe_n_i,
  input  wire logic                  read_write_select_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [BWM_DATA_W-1:0] data_i,
  input  wire logic [BWM_SEL_W-1:0]  byte_lane_select_n_i,
  output logic                       write_ready_o,
  // avalon-mm slave
  input  wire logic [4:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o
);

  localparam int DEPTH  = 1 << ADDR_W;
  localparam int ENT_W  = ADDR_W + 2 * BWM_DATA_W;
  localparam int LVL_W  = $clog2(BWM_FIFO_DEP + 1);

  typedef struct packed {
    bwm_wr_state_e                     wr_state;
    logic                              pos_prev;
    logic                              neg_prev;
    logic [ADDR_W-1:0]                 burst_addr;
    logic [ADDR_W-1:0]                 pend_addr;
    logic                              pend_valid;
    logic [1:0]                        org;
    logic                              hold_drain;
    logic                              overflow;
    logic [15:0]                       beat_count;
    logic [ADDR_W-1:0]                 mem_addr;
    logic                              waitrequest;
    logic [31:0]                       readdata;
    logic                              write_ready;
    logic [DEPTH-1:0][BWM_DATA_W-1:0]  mem;
  } bwm_state_s;

  bwm_state_s              s_reg;
  bwm_state_s              s_next;

  logic                    pos_rise;
  logic                    neg_rise;
  logic                    wr_start;
  logic                    push_valid;
  logic [ADDR_W-1:0]       push_addr;
  logic [BWM_DATA_W-1:0]   push_mask;
  logic [ENT_W-1:0]        push_ent;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [ENT_W-1:0]        fifo_out_ent;
  logic [LVL_W-1:0]        fifo_level;
  logic [ADDR_W-1:0]       drain_addr;
  logic [BWM_DATA_W-1:0]   drain_data;
  logic [BWM_DATA_W-1:0]   drain_mask;
  logic                    bus_req;
  logic                    bus_take;
  logic                    bus_aligned;
  logic [31:0]             status_word;
  logic [BWM_DATA_W-1:0]   rd_word;

  // active-low selects to a per-bit write mask for the current organisation
  function automatic logic [BWM_DATA_W-1:0] lane_bits(
    input logic [1:0]           org,
    input logic [BWM_SEL_W-1:0] sel_n
  );
    logic [BWM_DATA_W-1:0] m;
    m = '0;
    case (org)
      BWM_ORG_X8:
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (!sel_n[i])
          begin
            m[i*BWM_NIB_W +: BWM_NIB_W] = '1; // R4 R5 R6 R10
          end
        end
      end
      BWM_ORG_X9:
      begin
        if (!sel_n[0])
        begin
          m[BWM_LANE_W-1:0] = '1; // R11
        end
      end
      BWM_ORG_X18:
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (!sel_n[i])
          begin
            m[i*BWM_LANE_W +: BWM_LANE_W] = '1; // R7 R8 R9 R10
          end
        end
      end
      default:
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (!sel_n[i])
          begin
            m[i*BWM_LANE_W +: BWM_LANE_W] = '1; // R12 R13 R14 R15 R16 R17
          end
        end
      end
    endcase
    return m;
  endfunction

  // strobe edges, pins taken as synchronous
  assign pos_rise = pos_strobe_i && !s_reg.pos_prev;
  assign neg_rise = neg_strobe_i && !s_reg.neg_prev;
  assign wr_start = pos_rise && !load_strobe_n_i && !read_write_select_i; // R1

  // beat capture: each beat carries its own selects and address
  always_comb
  begin
    push_valid = 1'b0;
    push_addr  = s_reg.burst_addr;
    case (s_reg.wr_state)
      BWM_ST_BEAT0:
      begin
        push_valid = pos_rise; // R2 R3
        push_addr  = s_reg.burst_addr;
      end
      BWM_ST_BEAT1:
      begin
        push_valid = neg_rise; // R2 R3
        push_addr  = s_reg.burst_addr + 1'b1; // R18
      end
      default:
      begin
        push_valid = 1'b0;
      end
    endcase
  end

  assign push_mask = lane_bits(s_reg.org, byte_lane_select_n_i); // R3 R18
  assign push_ent  = {push_addr, data_i & push_mask, push_mask};

  // queue of masked beats between pins and array
  bwm_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (BWM_FIFO_DEP)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_ent),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_ent),
    .level_o     (fifo_level)
  );

  assign fifo_out_ready = !s_reg.hold_drain;
  assign drain_addr     = fifo_out_ent[ENT_W-1 -: ADDR_W];
  assign drain_data     = fifo_out_ent[2*BWM_DATA_W-1 -: BWM_DATA_W];
  assign drain_mask     = fifo_out_ent[BWM_DATA_W-1:0];

  // bus decode, answered one cycle after the request
  assign bus_req     = avs_read_i || avs_write_i;
  assign bus_take    = bus_req && !s_reg.waitrequest;
  assign bus_aligned = (avs_address_i[1:0] == 2'h0);
  assign rd_word     = s_reg.mem[s_reg.mem_addr];

  // status word built from live state
  always_comb
  begin
    status_word = '0;
    status_word[BWM_ST_EMPTY_BIT] = !fifo_out_valid;
    status_word[BWM_ST_FULL_BIT]  = !fifo_in_ready;
    status_word[BWM_ST_OVF_BIT]   = s_reg.overflow;
    status_word[BWM_ST_BUSY_BIT]  = (s_reg.wr_state != BWM_ST_IDLE);
    status_word[BWM_ST_LVL_LSB +: LVL_W] = fifo_level;
    status_word[BWM_ST_CNT_LSB +: 16]    = s_reg.beat_count;
  end

  // next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.pos_prev    = pos_strobe_i;
    s_next.neg_prev    = neg_strobe_i;
    s_next.write_ready = fifo_in_ready;

    // burst sequencer
    case (s_reg.wr_state)
      BWM_ST_IDLE:
      begin
        if (wr_start)
        begin
          s_next.burst_addr = addr_i; // R1
          s_next.wr_state   = BWM_ST_BEAT0;
        end
      end
      BWM_ST_BEAT0:
      begin
        if (pos_rise)
        begin
          s_next.wr_state = BWM_ST_BEAT1;
          if (wr_start)
          begin
            s_next.pend_addr  = addr_i; // back-to-back burst
            s_next.pend_valid = 1'b1;
          end
        end
      end
      BWM_ST_BEAT1:
      begin
        if (neg_rise)
        begin
          if (s_reg.pend_valid)
          begin
            s_next.burst_addr = s_reg.pend_addr;
            s_next.pend_valid = 1'b0;
            s_next.wr_state   = BWM_ST_BEAT0;
          end
          else
          begin
            s_next.wr_state = BWM_ST_IDLE;
          end
        end
      end
      default:
      begin
        s_next.wr_state   = BWM_ST_IDLE;
        s_next.pend_valid = 1'b0;
      end
    endcase

    // beats counted when queued
    if (push_valid && fifo_in_ready)
    begin
      s_next.beat_count = s_reg.beat_count + 1'b1;
    end

    // array update: only unmasked bits change
    if (fifo_out_valid && fifo_out_ready)
    begin
      s_next.mem[drain_addr] = (s_reg.mem[drain_addr] & ~drain_mask)
                             | (drain_data & drain_mask); // R18
    end

    // bus handshake
    s_next.waitrequest = 1'b1;
    if (bus_req && s_reg.waitrequest)
    begin
      s_next.waitrequest = 1'b0;
      s_next.readdata    = 32'h0000_0000;
      if (avs_read_i && bus_aligned)
      begin
        case (avs_address_i)
          BWM_CTRL_OFS:
          begin
            s_next.readdata[BWM_CTRL_ORG_LSB +: 2] = s_reg.org;
            s_next.readdata[BWM_CTRL_HOLD_BIT]     = s_reg.hold_drain;
          end
          BWM_STATUS_OFS:  s_next.readdata = status_word;
          BWM_MADDR_OFS:   s_next.readdata[ADDR_W-1:0] = s_reg.mem_addr;
          BWM_MDATA_L_OFS: s_next.readdata = rd_word[31:0];
          BWM_MDATA_H_OFS: s_next.readdata[BWM_DATA_W-33:0] = rd_word[BWM_DATA_W-1:32];
          default:         s_next.readdata = 32'h0000_0000;
        endcase
      end
    end

    // register writes take effect on the edge after the answer, while waitrequest is low
    if (bus_take && avs_write_i && bus_aligned && avs_byteenable_i[0])
    begin
      case (avs_address_i)
        BWM_CTRL_OFS:
        begin
          s_next.org        = avs_writedata_i[BWM_CTRL_ORG_LSB +: 2];
          s_next.hold_drain = avs_writedata_i[BWM_CTRL_HOLD_BIT];
        end
        BWM_STATUS_OFS:
        begin
          if (avs_writedata_i[BWM_ST_OVF_BIT])
          begin
            s_next.overflow = 1'b0;
          end
        end
        BWM_MADDR_OFS:
        begin
          s_next.mem_addr = avs_writedata_i[ADDR_W-1:0];
        end
        default:
        begin
          s_next.mem_addr = s_reg.mem_addr;
        end
      endcase
    end

    // dropped beat sets overflow, winning over a clear
    if (push_valid && !fifo_in_ready)
    begin
      s_next.overflow = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_reg             <= '0;
      s_reg.wr_state    <= BWM_ST_IDLE;
      s_reg.org         <= BWM_ORG_RST;
      s_reg.hold_drain  <= BWM_HOLD_RST;
      s_reg.waitrequest <= 1'b1;
      s_reg.write_ready <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign avs_waitrequest_o = s_reg.waitrequest;
  assign avs_readdata_o    = s_reg.readdata;
  assign write_ready_o     = s_reg.write_ready;

endmodule

//--- bwm_write_lane_mask_chk.sv
`timescale 1ns/10ps
module bwm_write_lane_mask_chk
  import bwm_pkg::*;
#(
  parameter int ADDR_W = 6
)
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o
);
  logic req;
  logic rdq;
  // request taken at this edge
  assign req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign rdq = avs_read_i && avs_waitrequest_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // answer timing
  chk_wait_answer: assert property (req |=> !avs_waitrequest_o)
    else $error("request not answered");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer too long");
  chk_no_spur_ack: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("answer without request");
  chk_rdata_hold: assert property (!$stable(avs_readdata_o) |-> !avs_waitrequest_o)
    else $error("read data moved outside answer");
  // read data contents
  chk_unmapped_zero: assert property (rdq && (avs_address_i[1:0] != 2'h0
    || avs_address_i > BWM_MDATA_H_OFS) |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_hword_upper:
    assert property (rdq && avs_address_i == BWM_MDATA_H_OFS |=> avs_readdata_o[31:4] == 28'h0)
    else $error("upper word bits set");
  chk_ctrl_upper: assert property (rdq && avs_address_i == BWM_CTRL_OFS
    |=> avs_readdata_o[31:3] == 29'h0) else $error("control spare bits set");
  chk_maddr_upper: assert property (rdq && avs_address_i == BWM_MADDR_OFS
    |=> avs_readdata_o[31:ADDR_W] == '0) else $error("address spare bits set");
endmodule
bind bwm_write_lane_mask bwm_write_lane_mask_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

//--- bwm_ctl_model.sv
`timescale 1ns/10ps
module bwm_ctl_model
  import bwm_pkg::*;
#(
  parameter int ADDR_W = 6
)
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              go_i,
  input  wire logic              rw_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [35:0]       d0_i,
  input  wire logic [35:0]       d1_i,
  input  wire logic [3:0]        s0_i,
  input  wire logic [3:0]        s1_i,
  output logic                   busy_o,
  output logic                   pos_o,
  output logic                   neg_o,
  output logic                   load_n_o,
  output logic                   rw_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [35:0]            data_o,
  output logic [3:0]             sel_n_o
);
  logic [1:0] ph;
  logic [1:0] st;
  // strobes run free, two cycles each; burst pins follow them
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      {ph, st, busy_o, pos_o, neg_o, addr_o, data_o} <= '0;
      {load_n_o, rw_o, sel_n_o} <= 6'h3F;
    end
    else
    begin
      ph <= ph + 2'h1;
      pos_o <= ~^ph;
      neg_o <= ^ph;
      if (ph == 2'h3)
      begin
        load_n_o <= 1'b1;
        rw_o <= 1'b1;
        if (st == 2'h1)
        begin
          {data_o, sel_n_o} <= {d0_i, s0_i};
          st <= 2'h2;
        end
        else if (st == 2'h3)
        begin
          {addr_o, data_o, sel_n_o} <= ~{addr_o, data_o, sel_n_o}; // lines driven to their inverse
          st <= 2'h0;
          busy_o <= 1'b0;
        end
        else if (go_i && !busy_o)
        begin
          {load_n_o, rw_o, addr_o} <= {1'b0, rw_i, addr_i};
          st <= 2'h1;
          busy_o <= 1'b1;
        end
      end
      else if (ph == 2'h1 && st == 2'h2)
      begin
        {data_o, sel_n_o} <= {d1_i, s1_i};
        st <= 2'h3;
      end
    end
  end
endmodule

//--- test_bwm_write_lane_mask.sv
`timescale 1ns/10ps
module test_bwm_write_lane_mask import bwm_pkg::*;;
  logic        clk_i = 1'b0, reset_n_i = 1'b1, go = 1'b0, busy, pos, neg, load_n, rw, wrdy;
  logic        grw = 1'b0;
  logic [5:0]  ga = 6'h00, pa;
  logic [35:0] gd0 = '0, gd1 = '0, pd, sh [64] = '{default: '0};
  logic [3:0]  gs0 = 4'hF, gs1 = 4'hF, ps;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0, wr = 1'b0, wreq;
  logic [31:0] wd = 32'h0, rdat;
  int          n_errors = 0, check_count = 0;
  bwm_ctl_model #(.ADDR_W(6)) u_ctl (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go),
    .rw_i(grw), .addr_i(ga), .d0_i(gd0), .d1_i(gd1), .s0_i(gs0), .s1_i(gs1), .busy_o(busy),
    .pos_o(pos), .neg_o(neg), .load_n_o(load_n), .rw_o(rw), .addr_o(pa), .data_o(pd),
    .sel_n_o(ps));
  bwm_write_lane_mask #(.ADDR_W(6)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .pos_strobe_i(pos), .neg_strobe_i(neg), .load_strobe_n_i(load_n),
    .read_write_select_i(rw), .addr_i(pa), .data_i(pd), .byte_lane_select_n_i(ps),
    .write_ready_o(wrdy), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq));
  always #50 clk_i = ~clk_i;
  // comparison and run end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one slave bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk_i);
    {adr, wd, wr, rd} <= {a, d, w, !w};
    @(posedge clk_i);
    for (n = 0; n < 50 && wreq !== 1'b0; n++) @(posedge clk_i);
    r = rdat;
    {wr, rd} <= 2'b00;
    if (n >= 50) hang();
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rreg(input logic [4:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  // lanes that a beat may write
  function automatic logic [35:0] lmask(input logic [1:0] o, input logic [3:0] s);
    case (o)
      BWM_ORG_X8: return {28'h0, {4{!s[1]}}, {4{!s[0]}}};
      BWM_ORG_X9: return {27'h0, {9{!s[0]}}};
      BWM_ORG_X18: return {18'h0, {9{!s[1]}}, {9{!s[0]}}};
      default: return {{9{!s[3]}}, {9{!s[2]}}, {9{!s[1]}}, {9{!s[0]}}};
    endcase
  endfunction
  // one burst, every bit inverted against the stored word
  task automatic fire(input logic [1:0] o, input logic [5:0] a, input logic [3:0] s0, s1,
                      input logic upd);
    int n;
    logic [5:0] b;
    b = a + 6'h1;
    @(posedge clk_i);
    {ga, gd0, gd1, gs0, gs1, go} <= {a, ~sh[a], ~sh[b], s0, s1, 1'b1};
    if (upd)
    begin
      sh[a] = sh[a] ^ lmask(o, s0);
      sh[b] = sh[b] ^ lmask(o, s1);
    end
    @(posedge clk_i);
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge clk_i);
    go <= 1'b0;
    if (n >= 20) hang();
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(posedge clk_i);
    if (n >= 20) hang();
  endtask
  task automatic idle();
    logic [31:0] r;
    int n;
    for (n = 0; n < 40; n++)
    begin
      rreg(BWM_STATUS_OFS, r);
      if (r[0] === 1'b1 && r[3] === 1'b0) return;
    end
    hang();
  endtask
  task automatic cword(input logic [5:0] a);
    logic [31:0] lo, hi;
    wreg(BWM_MADDR_OFS, {26'h0, a});
    rreg(BWM_MDATA_L_OFS, lo);
    rreg(BWM_MDATA_H_OFS, hi);
    chk({hi[3:0], lo}, sh[a]);
  endtask
  task automatic burst(input logic [1:0] o, input logic [5:0] a, input logic [3:0] s0, s1);
    wreg(BWM_CTRL_OFS, {30'h0, o});
    fire(o, a, s0, s1, 1'b1);
    idle();
    cword(a);
    cword(a + 6'h1);
  endtask
  // reset values and unmapped places
  task automatic t_reset();
    logic [31:0] r;
    rreg(BWM_STATUS_OFS, r);
    chk(36'({r[13:8], r[3:0]}), 36'h1);
    chk(36'(r[31:16]), 36'h0);
    rreg(BWM_MADDR_OFS, r);
    chk(36'(r), 36'h0);
    wreg(5'h14, 32'hFFFF_FFFF);
    wreg(5'h01, 32'h0000_0000);
    rreg(5'h14, r);
    chk(36'(r), 36'h0);
    rreg(5'h0D, r);
    chk(36'(r), 36'h0);
    rreg(BWM_CTRL_OFS, r);
    chk(36'(r), 36'h3);
    chk(36'(wrdy), 36'h1);
    $display("test reset done");
  endtask
  // each organisation and select pattern, selects differing per beat
  task automatic t_mask();
    burst(BWM_ORG_X8, 6'h00, 4'h0, 4'hE);
    burst(BWM_ORG_X8, 6'h02, 4'hD, 4'hF);
    burst(BWM_ORG_X9, 6'h04, 4'hE, 4'h1);
    burst(BWM_ORG_X18, 6'h06, 4'hC, 4'hE);
    burst(BWM_ORG_X18, 6'h08, 4'hD, 4'hF);
    burst(BWM_ORG_X36, 6'h0A, 4'h0, 4'hE);
    burst(BWM_ORG_X36, 6'h0C, 4'hD, 4'hB);
    burst(BWM_ORG_X36, 6'h3F, 4'h7, 4'hF);
    $display("test mask done");
  endtask
  // read command on the pins: no beat taken, words and count unchanged
  task automatic t_rdcmd();
    logic [31:0] r;
    grw <= 1'b1;
    fire(BWM_ORG_X36, 6'h0A, 4'h0, 4'h0, 1'b0);
    grw <= 1'b0;
    idle();
    cword(6'h0A);
    cword(6'h0B);
    rreg(BWM_STATUS_OFS, r);
    chk(36'(r[31:16]), 36'h10);
    $display("test read command done");
  endtask
  // queue filled past full while drain is held, then drained
  task automatic t_fill();
    logic [31:0] r;
    int k;
    wreg(BWM_CTRL_OFS, 32'h7);
    for (k = 0; k < 17; k++) fire(BWM_ORG_X36, 6'(16 + 2 * k), 4'h0, 4'h0, k < 16);
    chk(36'(wrdy), 36'h0);
    rreg(BWM_STATUS_OFS, r);
    chk(36'({r[13:8], r[3:0]}), 36'h206);
    chk(36'(r[31:16]), 36'h30);
    wreg(BWM_STATUS_OFS, 32'h4);
    rreg(BWM_STATUS_OFS, r);
    chk(36'(r[2:0]), 36'h2);
    wreg(BWM_CTRL_OFS, 32'h3);
    idle();
    chk(36'(wrdy), 36'h1);
    for (k = 16; k < 50; k++) cword(6'(k));
    $display("test fill done");
  endtask
  initial
  begin
    reset_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_mask();
    t_rdcmd();
    t_fill();
    test_done();
  end
endmodule
